// ==== logic/serial_ctrl_pkg.sv ====
// ****************************************************************
// constants and carriers of the serial control word block
// ****************************************************************
package serial_ctrl_pkg;

  // register byte addresses on the bus, control reset value, zero fills and byte lane
  localparam logic [7:0]  CTRL_OFS   = 8'h00;
  localparam logic [7:0]  STATE_OFS  = 8'h04;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [23:0] PAD_ZERO   = 24'h000000;
  localparam logic [31:0] DATA_ZERO  = 32'h00000000;
  localparam int          LANE0      = 0;

  // control word layout, msb first
  typedef struct packed {
    logic tx_irq_en;
    logic rx_irq_en;
    logic tx_en;
    logic rx_en;
    logic multiproc_skip_en;
    logic tx_end_irq_en;
    logic clk_sel_hi;
    logic clk_sel_lo;
  } ctrl_word_t;

  // flags of the status word, kept elsewhere in the unit
  typedef struct packed {
    logic tx_buf_empty;
    logic rx_buf_full;
    logic overrun_flag;
    logic framing_err_flag;
    logic parity_err_flag;
    logic tx_end_flag;
  } unit_flags_t;

  // mode bits from the format word and the card mode word
  typedef struct packed {
    logic sync_mode;
    logic multiproc_format;
    logic card_mode_sel;
  } mode_t;

  // interrupt requests towards the interrupt controller
  typedef struct packed {
    logic tx_buf_irq;
    logic rx_full_irq;
    logic rx_err_irq;
    logic tx_end_irq;
  } irq_t;

  // clock source of the shifters
  typedef enum logic [1:0] {
    CLK_BAUD,
    CLK_EXT16,
    CLK_EXT_SHIFT
  } clk_src_t;

endpackage

// ==== logic/serial_ctrl_word_logic.sv ====
// Notes on behaviour
// [R1] transmit-end request follows flag when enabled
// [R2] transmit-end request drops with flag or enable
// [R3] async 00: baud generator, clock pin is port
// [R4] async 01: baud generator, pin drives bit clock
// [R5] async 1x: clock from pin, sixteen times rate
// [R6] sync 0x: internal clock driven on pin
// [R7] sync 1x: pin is input shift clock
// [R8] buffer request follows empty flag when enabled
// [R9] buffer request drops with flag or enable
// [R10] receive enable gates full and error requests
// [R11] receive requests drop with flags or enable
// [R12] transmit starts once buffer flag cleared
// [R13] transmit disabled holds empty flag at one
// [R14] software sets format before transmit enable
// [R15] receive starts on start bit or clock
// [R16] receive disable leaves receive flags alone
// [R17] software sets format before receive enable
// [R18] skip works only async with multiprocessor format
// [R19] software keeps two enables zero in card mode
// [R20] card mode select picks bit meanings
// [R21] skip drops zero frames, clears on one
// [R22] control word resets zero, plain read/write
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps

module serial_ctrl_word_logic (
  input  wire logic                       MCLK,
  input  wire logic                       RST,
  input  wire logic                       WB_CYC_I,
  input  wire logic                       WB_STB_I,
  input  wire logic                       WB_WE_I,
  input  wire logic [7:0]                 WB_ADR_I,
  input  wire logic [3:0]                 WB_SEL_I,
  input  wire logic [31:0]                WB_DAT_I,
  output logic [31:0]                     WB_DAT_O,
  output logic                            WB_ACK_O,
  input  wire serial_ctrl_pkg::unit_flags_t FLAGS,
  input  wire serial_ctrl_pkg::mode_t     MODE,
  input  wire logic                       BAUD_TICK,
  input  wire logic                       FRAME_DONE,
  input  wire logic                       ADDR_FLAG_BIT,
  input  wire logic                       SCK_I,
  input  wire logic                       RXD_I,
  output serial_ctrl_pkg::irq_t           IRQ,
  output logic                            SCK_O,
  output logic                            SCK_OE,
  output logic                            SCK_PORT,
  output serial_ctrl_pkg::clk_src_t       CLK_SRC,
  output logic                            EXT_TICK,
  output logic                            TX_GO,
  output logic                            TX_EMPTY_HOLD,
  output logic                            RX_START,
  output logic                            FRAME_DROP,
  output logic                            FLAG_SET_EN
);

  // ****************************************************************
  // register bus slave
  // ****************************************************************
  serial_ctrl_pkg::ctrl_word_t ctrl_r;
  serial_ctrl_pkg::ctrl_word_t ctrl_nxt;
  logic                        ack_r;
  logic                        ack_nxt;
  logic [31:0]                 dat_r;
  logic [31:0]                 dat_nxt;
  logic                        skip_active;
  logic                        mp_clear;
  logic                        req;
  logic                        wr_ctrl;
  logic [7:0]                  state_byte;

  // skip only counts in async multiprocessor format outside card mode
  assign skip_active = ctrl_r.multiproc_skip_en & ~MODE.sync_mode
                       & MODE.multiproc_format & ~MODE.card_mode_sel; // [R18] [R20]
  assign mp_clear    = skip_active & FRAME_DONE & ADDR_FLAG_BIT; // [R21]
  assign req         = WB_CYC_I & WB_STB_I & ~ack_r;
  // write lands at the edge where the master sees ack high, not before
  assign wr_ctrl     = WB_CYC_I & WB_STB_I & ack_r & WB_WE_I & WB_SEL_I[serial_ctrl_pkg::LANE0]
                       & (WB_ADR_I == serial_ctrl_pkg::CTRL_OFS);

  // next control word, ack and read data
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl)
    begin
      ctrl_nxt = serial_ctrl_pkg::ctrl_word_t'(WB_DAT_I[7:0]); // [R22]
    end
    else if (mp_clear)
    begin
      ctrl_nxt.multiproc_skip_en = 1'b0; // [R21]
    end
    ack_nxt = req;
    dat_nxt = serial_ctrl_pkg::DATA_ZERO;
    if (req && !WB_WE_I)
    begin
      case (WB_ADR_I)
        serial_ctrl_pkg::CTRL_OFS:  dat_nxt = {serial_ctrl_pkg::PAD_ZERO, ctrl_r}; // [R22]
        serial_ctrl_pkg::STATE_OFS: dat_nxt = {serial_ctrl_pkg::PAD_ZERO, state_byte};
        default:                    dat_nxt = serial_ctrl_pkg::DATA_ZERO;
      endcase
    end
  end

  // bus registers
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl_r <= serial_ctrl_pkg::ctrl_word_t'(serial_ctrl_pkg::CTRL_RST); // [R22]
      ack_r  <= 1'b0;
      dat_r  <= serial_ctrl_pkg::DATA_ZERO;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      ack_r  <= ack_nxt;
      dat_r  <= dat_nxt;
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;

  // ****************************************************************
  // link pin sampling and clock selection
  // ****************************************************************
  logic                      sck_s1_r;
  logic                      sck_s2_r;
  logic                      sck_s3_r;
  logic                      rxd_s1_r;
  logic                      rxd_s2_r;
  logic                      rxd_s3_r;
  logic                      sck_clk_r;
  logic                      sck_clk_nxt;
  logic                      drive_clk;
  logic                      sck_rise;
  logic                      rxd_fall;
  serial_ctrl_pkg::clk_src_t src_nxt;

  // pin drive decode per mode and clock select bits
  always_comb
  begin
    drive_clk = 1'b0;
    src_nxt   = serial_ctrl_pkg::CLK_BAUD;
    if (MODE.card_mode_sel)
    begin
      drive_clk = ctrl_r.clk_sel_lo; // [R20]
    end
    else if (MODE.sync_mode)
    begin
      drive_clk = ~ctrl_r.clk_sel_hi; // [R6]
      if (ctrl_r.clk_sel_hi)
      begin
        src_nxt = serial_ctrl_pkg::CLK_EXT_SHIFT; // [R7]
      end
    end
    else if (ctrl_r.clk_sel_hi)
    begin
      src_nxt = serial_ctrl_pkg::CLK_EXT16; // [R5]
    end
    else
    begin
      drive_clk = ctrl_r.clk_sel_lo; // [R3] [R4]
    end
    sck_clk_nxt = sck_clk_r;
    if (!drive_clk)
    begin
      sck_clk_nxt = 1'b0;
    end
    else if (BAUD_TICK)
    begin
      sck_clk_nxt = ~sck_clk_r; // [R4] two ticks make one bit period
    end
  end

  assign sck_rise = sck_s2_r & ~sck_s3_r;
  assign rxd_fall = ~rxd_s2_r & rxd_s3_r;

  // two-stage synchronisers plus edge history
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      sck_s1_r  <= 1'b0;
      sck_s2_r  <= 1'b0;
      sck_s3_r  <= 1'b0;
      rxd_s1_r  <= 1'b1;
      rxd_s2_r  <= 1'b1;
      rxd_s3_r  <= 1'b1;
      sck_clk_r <= 1'b0;
    end
    else
    begin
      sck_s1_r  <= SCK_I;
      sck_s2_r  <= sck_s1_r;
      sck_s3_r  <= sck_s2_r;
      rxd_s1_r  <= RXD_I;
      rxd_s2_r  <= rxd_s1_r;
      rxd_s3_r  <= rxd_s2_r;
      sck_clk_r <= sck_clk_nxt;
    end
  end

  // ****************************************************************
  // requests and control outputs
  // ****************************************************************
  serial_ctrl_pkg::irq_t irq_nxt;
  logic                  rx_go;
  logic                  ext_nxt;

  // interrupt requests are enable-and-flag terms, transmit-end also masked in card mode
  always_comb
  begin
    irq_nxt.tx_buf_irq  = ctrl_r.tx_irq_en & FLAGS.tx_buf_empty; // [R8] [R9]
    irq_nxt.rx_full_irq = ctrl_r.rx_irq_en & FLAGS.rx_buf_full; // [R10] [R11]
    irq_nxt.rx_err_irq  = ctrl_r.rx_irq_en & (FLAGS.overrun_flag
                          | FLAGS.framing_err_flag | FLAGS.parity_err_flag); // [R10] [R11]
    irq_nxt.tx_end_irq  = ctrl_r.tx_end_irq_en & FLAGS.tx_end_flag
                          & ~MODE.card_mode_sel; // [R1] [R2] [R20]
    ext_nxt = (src_nxt != serial_ctrl_pkg::CLK_BAUD) & sck_rise;
    rx_go   = 1'b0;
    if (ctrl_r.rx_en)
    begin
      if (!MODE.sync_mode)
      begin
        rx_go = rxd_fall; // [R15]
      end
      else if (ctrl_r.clk_sel_hi)
      begin
        rx_go = sck_rise; // [R15]
      end
      else
      begin
        rx_go = BAUD_TICK;
      end
    end
  end

  // output registers; receive flags are never touched here
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      IRQ           <= '0;
      SCK_O         <= 1'b0;
      SCK_OE        <= 1'b0;
      SCK_PORT      <= 1'b1;
      CLK_SRC       <= serial_ctrl_pkg::CLK_BAUD;
      EXT_TICK      <= 1'b0;
      TX_GO         <= 1'b0;
      TX_EMPTY_HOLD <= 1'b1;
      RX_START      <= 1'b0;
      FRAME_DROP    <= 1'b0;
      FLAG_SET_EN   <= 1'b1;
    end
    else
    begin
      IRQ           <= irq_nxt;
      SCK_O         <= sck_clk_nxt;
      SCK_OE        <= drive_clk; // [R4] [R6]
      SCK_PORT      <= ~drive_clk & (src_nxt == serial_ctrl_pkg::CLK_BAUD); // [R3]
      CLK_SRC       <= src_nxt;
      EXT_TICK      <= ext_nxt; // [R5] [R7]
      TX_GO         <= ctrl_r.tx_en & ~FLAGS.tx_buf_empty; // [R12]
      TX_EMPTY_HOLD <= ~ctrl_r.tx_en; // [R13]
      RX_START      <= rx_go; // [R15] [R16] receive flags stay with the status block
      FRAME_DROP    <= skip_active & FRAME_DONE & ~ADDR_FLAG_BIT; // [R21]
      FLAG_SET_EN   <= ~skip_active; // [R21]
    end
  end

  assign state_byte = {3'h0, skip_active, drive_clk, sck_s2_r, CLK_SRC};

  // ****************************************************************
  // checks
  // ****************************************************************
  localparam serial_ctrl_pkg::ctrl_word_t CTRL_Z = 8'h00;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  AST_TEI_FOLLOWS: assert property ( // [R1]
    irq_nxt.tx_end_irq |=> IRQ.tx_end_irq)
    else $error("transmit-end request missing");
  AST_TEI_OFF: assert property ( // [R2]
    !ctrl_r.tx_end_irq_en |=> !IRQ.tx_end_irq)
    else $error("transmit-end request while disabled");
  AST_TXI_GATE: assert property ( // [R8]
    (ctrl_r.tx_irq_en && FLAGS.tx_buf_empty) |=> IRQ.tx_buf_irq)
    else $error("buffer request missing");
  AST_TXI_DROP: assert property ( // [R9]
    !FLAGS.tx_buf_empty |=> !IRQ.tx_buf_irq)
    else $error("buffer request without flag");
  AST_RX_GATE: assert property ( // [R10]
    !ctrl_r.rx_irq_en |=> !(IRQ.rx_full_irq || IRQ.rx_err_irq))
    else $error("receive request while disabled");
  AST_PORT_MODE: assert property ( // [R3]
    (!MODE.card_mode_sel && !MODE.sync_mode && ctrl_r == CTRL_Z)
    |=> (SCK_PORT && !SCK_OE))
    else $error("clock pin not a port");
  AST_SYNC_DRIVE: assert property ( // [R6]
    (MODE.sync_mode && !MODE.card_mode_sel && !ctrl_r.clk_sel_hi) |=> SCK_OE)
    else $error("sync clock not driven");
  AST_EXT_INPUT: assert property ( // [R7]
    (!MODE.card_mode_sel && ctrl_r.clk_sel_hi) |=> !SCK_OE)
    else $error("driving pin in external clock mode");
  AST_TX_HOLD: assert property ( // [R13]
    !ctrl_r.tx_en |=> (TX_EMPTY_HOLD && !TX_GO))
    else $error("transmit active while disabled");
  AST_SKIP_CLEAR: assert property ( // [R21]
    (mp_clear && !wr_ctrl) |=> !ctrl_r.multiproc_skip_en)
    else $error("skip enable not cleared");
  AST_ACK_ONCE: assert property ( // [R22]
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held two cycles");

endmodule

// ==== testbench/serial_peer_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// remote serial peer: link clock and receive line
// ****************************************************************
module serial_peer_model (
  input  wire logic run,
  input  wire logic send,
  output logic      sck,
  output logic      rxd
);
  // link clock of 80 ns, still and low while run is low
  initial sck = 1'b0;
  always #40 sck = run ? ~sck : 1'b0;
  // idle mark high, start bit low for eight link periods
  initial rxd = 1'b1;
  always @(posedge send)
  begin
    rxd = 1'b0;
    #640;
    rxd = 1'b1;
  end
endmodule

// ==== testbench/serial_ctrl_word_logic_tb.sv ====
`timescale 1ns/1ps
// ****************************************************************
// bench of the serial control word block
// ****************************************************************
module serial_ctrl_word_logic_tb;
  logic                          mclk = 1'b0;
  logic                          rst = 1'b1;
  logic                          cyc = 1'b0;
  logic                          we_r = 1'b0;
  logic [7:0]                    adr = 8'h00;
  logic [31:0]                   dat = 32'h00000000;
  logic [31:0]                   rdat;
  logic [31:0]                   q;
  logic                          ack;
  logic                          frame = 1'b0;
  logic                          addr_flag_bit = 1'b0;
  logic                          run = 1'b0;
  logic                          send = 1'b0;
  logic                          peer_sck;
  logic                          rxd;
  logic                          sck_o;
  logic                          sck_oe;
  logic                          sck_port;
  logic                          ext_tick;
  logic                          tx_go;
  logic                          tx_hold;
  logic                          rx_start;
  logic                          frame_drop;
  logic                          flag_set_en;
  serial_ctrl_pkg::unit_flags_t  flags = 6'h21;
  serial_ctrl_pkg::mode_t        mode = 3'h0;
  serial_ctrl_pkg::irq_t         irq;
  serial_ctrl_pkg::clk_src_t     clk_src;
  int                            n_errors = 0;
  int                            compares = 0;
  int                            n_tick = 0;
  int                            n_rise = 0;
  int                            n_rxs = 0;
  int                            n_drop = 0;
  int                            n_out = 0;
  int                            n_div = 0;
  logic                          baud = 1'b0;
  logic                          sck_q = 1'b0;
  logic [31:0]                   e;

  always #5 mclk = ~mclk;

  // baud tick every fourth cycle, twice the link bit rate
  always @(posedge mclk)
  begin
    n_div <= (n_div + 1) % 4;
    baud <= (n_div == 0);
  end

  serial_ctrl_word_logic serial_ctrl_word_logic_i (
    .MCLK(mclk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we_r),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .FLAGS(flags), .MODE(mode), .BAUD_TICK(baud), .FRAME_DONE(frame), .ADDR_FLAG_BIT(addr_flag_bit),
    .SCK_I(sck_oe ? sck_o : peer_sck), .RXD_I(rxd), .IRQ(irq), .SCK_O(sck_o), .SCK_OE(sck_oe),
    .SCK_PORT(sck_port), .CLK_SRC(clk_src), .EXT_TICK(ext_tick), .TX_GO(tx_go),
    .TX_EMPTY_HOLD(tx_hold), .RX_START(rx_start), .FRAME_DROP(frame_drop), .FLAG_SET_EN(flag_set_en)
  );

  serial_peer_model serial_peer_model_i (.run(run), .send(send), .sck(peer_sck), .rxd(rxd));

  // ****************************************************************
  // event counters
  // ****************************************************************
  always @(posedge mclk)
  begin
    n_tick += (ext_tick === 1'b1);
    n_rxs += (rx_start === 1'b1);
    n_drop += (frame_drop === 1'b1);
    n_out += (sck_o === 1'b1 && sck_q === 1'b0);
    sck_q = sck_o;
  end
  always @(posedge peer_sck) n_rise++;

  // ****************************************************************
  // bus, compare and closing tasks
  // ****************************************************************
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    we_r <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    r = rdat;
    cyc <= 1'b0;
    if (ack !== 1'b1)
    begin
      n_errors++;
      $display("wrong value at %0t: bus timeout", $time);
      wrap_up();
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // expected clock source, pin drive and port role per sync and select bits
  function automatic logic [31:0] exp_clk(input logic [2:0] m);
    serial_ctrl_pkg::clk_src_t s;
    s = !m[1] ? serial_ctrl_pkg::CLK_BAUD : (m[2] ? serial_ctrl_pkg::CLK_EXT_SHIFT : serial_ctrl_pkg::CLK_EXT16);
    return {28'h0000000, s, !m[1] && (m[2] || m[0]), !m[2] && m[1:0] == 2'h0};
  endfunction

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    idle(10);
    rst <= 1'b0;
    wb(1'b0, serial_ctrl_pkg::CTRL_OFS, 32'h0, q);
    chk(q, 32'h00000000);
    wb(1'b1, serial_ctrl_pkg::CTRL_OFS, 32'hFFFFFFFF, q);
    wb(1'b0, serial_ctrl_pkg::CTRL_OFS, 32'h0, q);
    chk(q, 32'h000000FF);
    wb(1'b1, 8'h40, 32'hFF, q);
    wb(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h00000000);
    // interrupt requests follow flags and enables
    wb(1'b1, serial_ctrl_pkg::CTRL_OFS, 32'h84, q);
    idle(3);
    chk(irq, 32'h9);
    flags <= 6'h00;
    idle(3);
    chk(irq, 32'h0);
    flags <= 6'h21;
    wb(1'b1, serial_ctrl_pkg::CTRL_OFS, 32'h00, q);
    idle(3);
    chk(irq, 32'h0);
    flags <= 6'h18;
    wb(1'b1, serial_ctrl_pkg::CTRL_OFS, 32'h40, q);
    idle(3);
    chk(irq, 32'h6);
    flags <= 6'h00;
    idle(3);
    chk(irq, 32'h0);
    flags <= 6'h18;
    wb(1'b1, serial_ctrl_pkg::CTRL_OFS, 32'h00, q);
    idle(3);
    chk(irq, 32'h0);
    // transmit start and disabled hold; format chosen before the enable
    flags <= 6'h20;
    wb(1'b1, serial_ctrl_pkg::CTRL_OFS, 32'h20, q);
    idle(3);
    chk({tx_go, tx_hold}, 32'h0);
    flags <= 6'h00;
    idle(3);
    chk({tx_go, tx_hold}, 32'h2);
    wb(1'b1, serial_ctrl_pkg::CTRL_OFS, 32'h00, q);
    idle(3);
    chk({tx_go, tx_hold}, 32'h1);
    // every clock mode, with the peer clock running and the baud tick live
    for (int i = 0; i < 8; i++)
    begin
      mode <= {i[2], 2'h0};
      wb(1'b1, serial_ctrl_pkg::CTRL_OFS, {30'h0, i[1:0]}, q);
      idle(6);
      e = exp_clk(i[2:0]);
      chk({28'h0, clk_src, sck_oe, sck_port}, e);
      n_tick = 0;
      n_rise = 0;
      n_out = 0;
      run <= 1'b1;
      idle(48);
      run <= 1'b0;
      idle(12);
      chk(n_tick, i[1] ? n_rise : 0);
      chk({n_out >= 7, n_out > 0}, e[1] ? 32'h3 : 32'h0);
    end
    // start bit detection, refused then accepted
    mode <= 3'h0;
    for (int j = 0; j < 2; j++)
    begin
      wb(1'b1, serial_ctrl_pkg::CTRL_OFS, j ? 32'h10 : 32'h00, q);
      idle(3);
      n_rxs = 0;
      send <= 1'b1;
      idle(80);
      send <= 1'b0;
      chk(n_rxs, j);
    end
    // frame skipping, without and with multiprocessor format
    for (int j = 0; j < 2; j++)
    begin
      mode <= {1'b0, j[0], 1'b0};
      wb(1'b1, serial_ctrl_pkg::CTRL_OFS, 32'h18, q);
      idle(3);
      chk(flag_set_en, !j[0]);
      n_drop = 0;
      for (int b = 0; b < 2; b++)
      begin
        frame <= 1'b1;
        addr_flag_bit <= b[0];
        idle(1);
        frame <= 1'b0;
        idle(3);
      end
      chk(n_drop, j);
    end
    wb(1'b0, serial_ctrl_pkg::CTRL_OFS, 32'h0, q);
    chk(q, 32'h10);
    // card mode: pin driven on the low select bit, skip and end enables kept 0
    flags <= 6'h01;
    mode <= 3'h1;
    wb(1'b1, serial_ctrl_pkg::CTRL_OFS, 32'h03, q);
    idle(3);
    chk({irq, sck_oe, sck_port}, 32'h02);
    mode <= 3'h0;
    idle(3);
    chk({irq, sck_oe, sck_port}, 32'h00);
    wb(1'b1, serial_ctrl_pkg::CTRL_OFS, 32'h04, q);
    idle(3);
    chk(irq, 32'h1);
    wrap_up();
  end
endmodule
